// ---- logic/scqs_clk_mon.sv ----
/*
  clock monitor: flags a failure when oscillator edges come too far apart.
  assumes osc_tick_i is a one-cycle pulse per oscillator edge, synchronous
  to core_clk_i.
*/
`timescale 1ns/100ps
`include "scqs_consts.svh"

module scqs_clk_mon (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // monitor control
  input  wire logic enable_i,
  input  wire logic osc_tick_i,
  // result
  output logic      fail_o
);

  localparam logic [15:0] GAP_CYC = 16'(`SCQS_MON_GAP_CYC);

  logic [15:0] gap_r;    // cycles since last edge
  logic [15:0] gap_nxt;
  logic        fail_r;   // sticky until next edge or until enable_i drops
  logic        fail_nxt;

  // gap counter; frequency below threshold means gap above limit
  always_comb begin
    gap_nxt  = gap_r;
    fail_nxt = fail_r;
    if (!enable_i || osc_tick_i) begin
      gap_nxt  = 16'h0000;
      fail_nxt = 1'b0;
    end else if (gap_r >= GAP_CYC) begin
      fail_nxt = 1'b1;
    end else begin
      gap_nxt = gap_r + 16'h0001;
    end
  end

  // registers only
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      gap_r  <= 16'h0000;
      fail_r <= 1'b0;
    end else begin
      gap_r  <= gap_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign fail_o = fail_r;

endmodule

// ---- logic/scqs_consts.svh ----
/*
  constants for the startup clock quality sequencer: timing figures,
  derived cycle counts and reset values.
  assumes a 40 MHz core clock that is the internal self clock.
*/
`ifndef SCQS_CONSTS_SVH
`define SCQS_CONSTS_SVH

// core clock rate
`define SCQS_CLK_HZ          40000000

// quality check time-out window, in ms (0.45 s to 2.5 s)
`define SCQS_CQ_TOUT_MIN_MS  450
`define SCQS_CQ_TOUT_MAX_MS  2500
// shortest legal time-out, rounded down to cycles
`define SCQS_CQ_TOUT_CYC     ((`SCQS_CQ_TOUT_MIN_MS * (`SCQS_CLK_HZ / 1000)))

// oscillator edges needed to call the oscillation good
`define SCQS_CQ_TICKS        16'h1000

// minimum reset pulse, in oscillator periods
`define SCQS_MIN_RST_TICKS   2'h2

// wait recovery, in bus cycles (at most 14)
`define SCQS_WRS_CYC         4'hE

// clock monitor assert threshold, in kHz (50 to 200, typ 100)
`define SCQS_MON_KHZ         100
// longest tick gap tolerated before a monitor failure, rounded down
`define SCQS_MON_GAP_CYC     ((`SCQS_CLK_HZ / 1000) / `SCQS_MON_KHZ)

// reset values
`define SCQS_RST_OSC_SEL     1'h0
`define SCQS_RST_POWER_ON_RESET_FLAG        1'h1

`endif

// ---- logic/scqs_pkg.sv ----
/*
  types of the startup clock quality sequencer: state enum and grouped
  request signals.
  assumes nothing beyond a SystemVerilog compiler.
*/
package scqs_pkg;

  // one-hot sequencer states
  typedef enum logic [8:0] {
    ST_RESET = 9'h001,  // internal reset held
    ST_CQC   = 9'h002,  // quality check running
    ST_RUN   = 9'h004,  // oscillator drives system
    ST_SCM   = 9'h008,  // self clock mode
    ST_STOP  = 9'h010,  // full stop, oscillator off
    ST_PSTOP = 9'h020,  // pseudo stop, regulator reduced
    ST_WAIT  = 9'h040,  // wait mode
    ST_VUP   = 9'h080,  // regulator returning to full
    ST_WRS   = 9'h100   // wait recovery delay
  } scqs_state_e;

  // low power requests from the cpu
  typedef struct packed {
    logic stop;
    logic pstop;
    logic wait_m;
  } scqs_lp_req_s;

  // wake sources
  typedef struct packed {
    logic irq_int;
    logic irq_ext;
  } scqs_wake_s;

endpackage

// ---- logic/scqs_seq.sv ----
/*
  startup and recovery sequencer of the clock and reset unit: oscillator
  start, quality check, self clock fallback, external reset qualification,
  low power entry and wake, strap sampling and power-on flag.
  assumes all inputs synchronous to core_clk_i, which is the self clock.
*/
`timescale 1ns/100ps
`include "scqs_consts.svh"

// Operation
// - por release starts oscillator and quality check
// - no oscillation before time-out gives self clock
// - low-voltage release does the same as por
// - qualified reset skips check if oscillator ran
// - wait wake fetches vector within 14 cycles
// - pseudo stop wake waits regulator, then delay
// - pseudo stop reduces regulator, keeps oscillator
// - internal or external interrupt exits wait and pseudo stop; only external exits stop
// - stop wake runs quality check before clocks
// - strap sampled in reset selects oscillator type
// - quality check on por, stop, oscillator fail
// - monitor flags clock below threshold frequency
module scqs_seq #(
  parameter int unsigned CQ_TOUT_CYC = `SCQS_CQ_TOUT_CYC
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // supply resets, high while asserted
  input  wire logic                  por_i,
  input  wire logic                  low_voltage_reset_i,
  // reset pin, low while asserted
  input  wire logic                  ext_rst_n_i,
  // oscillator edge pulse and strap
  input  wire logic                  osc_tick_i,
  input  wire logic                  osc_select_strap_i,
  // cpu requests and wake sources
  input  wire scqs_pkg::scqs_lp_req_s lp_req_i,
  input  wire scqs_pkg::scqs_wake_s   wake_i,
  // regulator back at full performance
  input  wire logic                  reg_full_i,
  // software clear of the power-on flag
  input  wire logic                  power_on_reset_flag_clr_i,
  // clock control
  output logic                       osc_enable_o,
  output logic                       sys_clk_osc_o,
  output logic                       self_clock_mode_o,
  output logic                       cq_active_o,
  output logic                       reg_reduced_o,
  output logic                       osc_select_o,
  // reset and vector fetch
  output logic                       int_reset_o,
  output logic                       fetch_rst_vec_o,
  output logic                       fetch_irq_vec_o,
  // status
  output logic                       power_on_reset_flag_o,
  output logic                       clk_mon_fail_o
);

  localparam logic [24:0] TOUT = 25'(CQ_TOUT_CYC);

  scqs_pkg::scqs_state_e state_r, state_nxt;  // sequencer state
  logic [24:0] tout_r, tout_nxt;    // self clock time-out count
  logic [15:0] tick_r, tick_nxt;    // good oscillator edges
  logic [1:0]  rpin_r, rpin_nxt;    // osc edges while pin low
  logic        osc_ok_r, osc_ok_nxt;    // oscillation existed
  logic        irq_path_r, irq_path_nxt; // check ends in irq fetch
  logic        power_on_reset_flag_r, power_on_reset_flag_nxt;    // power-on flag
  logic        sel_r, sel_nxt;      // sampled strap
  logic        frv_r, frv_nxt;      // reset vector pulse
  logic        fiv_r, fiv_nxt;      // irq vector pulse
  logic [3:0]  wrs_r, wrs_nxt;      // wait recovery count
  logic        mon_fail;            // from clock monitor
  logic        pin_rst;             // qualified pin reset
  logic        supply_rst;          // por or low voltage held
  logic        woke;                // any wake source
  logic        osc_en_r, osc_en_nxt;    // oscillator enable output flop
  logic        sys_osc_r, sys_osc_nxt;  // oscillator drives system
  logic        scm_r, scm_nxt;          // self clock mode output flop
  logic        cq_r, cq_nxt;            // check running output flop
  logic        red_r, red_nxt;          // regulator reduced output flop
  logic        irst_r, irst_nxt;        // internal reset output flop

  // wake from either interrupt source
  function automatic logic any_wake(input scqs_pkg::scqs_wake_s w);
    any_wake = w.irq_int | w.irq_ext;
  endfunction

  // running states where the monitor may act
  function automatic logic osc_live(input scqs_pkg::scqs_state_e s);
    osc_live = (s == scqs_pkg::ST_RUN) || (s == scqs_pkg::ST_PSTOP) ||
               (s == scqs_pkg::ST_WAIT) || (s == scqs_pkg::ST_VUP) ||
               (s == scqs_pkg::ST_WRS);
  endfunction

  assign supply_rst = por_i | low_voltage_reset_i;
  assign pin_rst    = !ext_rst_n_i && (rpin_r == `SCQS_MIN_RST_TICKS);
  assign woke       = any_wake(wake_i);

  // monitor watches the oscillator only while it should be running
  scqs_clk_mon u_mon (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .enable_i   (osc_live(state_r)),
    .osc_tick_i (osc_tick_i),
    .fail_o     (mon_fail)
  );

  // pin pulse qualifier: count oscillator edges while the pin is low
  always_comb begin
    rpin_nxt = rpin_r;
    if (ext_rst_n_i) begin
      rpin_nxt = 2'h0;
    end else if (osc_tick_i && rpin_r != `SCQS_MIN_RST_TICKS) begin
      rpin_nxt = rpin_r + 2'h1;
    end
  end

  // flags: power-on flag, strap, oscillation history
  always_comb begin
    power_on_reset_flag_nxt   = power_on_reset_flag_r;
    sel_nxt    = sel_r;
    osc_ok_nxt = osc_ok_r;
    // set beats clear in the same cycle
    if (por_i) begin
      power_on_reset_flag_nxt = 1'b1;
    end else if (power_on_reset_flag_clr_i) begin
      power_on_reset_flag_nxt = 1'b0;
    end
    // strap tracked while reset is held, frozen at release
    if (state_r == scqs_pkg::ST_RESET) begin
      sel_nxt = osc_select_strap_i;
    end
    if (supply_rst || mon_fail || state_r == scqs_pkg::ST_STOP) begin
      osc_ok_nxt = 1'b0;
    end else if (state_r == scqs_pkg::ST_CQC && tick_r == `SCQS_CQ_TICKS) begin
      osc_ok_nxt = 1'b1;
    end
  end

  // main sequencer
  always_comb begin
    state_nxt    = state_r;
    tout_nxt     = tout_r;
    tick_nxt     = tick_r;
    irq_path_nxt = irq_path_r;
    frv_nxt      = 1'b0;
    fiv_nxt      = 1'b0;
    wrs_nxt      = wrs_r;
    if (supply_rst) begin
      // supply reset overrides all; check starts at release
      state_nxt    = scqs_pkg::ST_RESET;
      irq_path_nxt = 1'b0;
      tout_nxt     = 25'h0;
      tick_nxt     = 16'h0000;
    end else if (pin_rst) begin
      state_nxt    = scqs_pkg::ST_RESET;
      irq_path_nxt = 1'b0;
    end else begin
      case (state_r)
        scqs_pkg::ST_RESET: begin
          // wait for the pin to let go
          if (ext_rst_n_i) begin
            if (osc_ok_r) begin
              state_nxt = scqs_pkg::ST_RUN;
              frv_nxt   = 1'b1;
            end else begin
              state_nxt = scqs_pkg::ST_CQC;
              tout_nxt  = 25'h0;
              tick_nxt  = 16'h0000;
            end
          end
        end
        scqs_pkg::ST_CQC: begin
          // time-out runs on the self clock so a dead crystal still ends it
          if (tick_r == `SCQS_CQ_TICKS) begin
            state_nxt = scqs_pkg::ST_RUN;
            frv_nxt   = !irq_path_r;
            fiv_nxt   = irq_path_r;
          end else if (tout_r >= TOUT - 25'h1) begin
            state_nxt = scqs_pkg::ST_SCM;
            frv_nxt   = !irq_path_r;
            fiv_nxt   = irq_path_r;
          end else begin
            tout_nxt = tout_r + 25'h1;
            if (osc_tick_i) begin
              tick_nxt = tick_r + 16'h0001;
            end
          end
        end
        scqs_pkg::ST_RUN: begin
          // oscillator failure forces a new check
          if (mon_fail) begin
            state_nxt    = scqs_pkg::ST_CQC;
            irq_path_nxt = 1'b0;
            tout_nxt     = 25'h0;
            tick_nxt     = 16'h0000;
          end else if (lp_req_i.stop) begin
            state_nxt = scqs_pkg::ST_STOP;
          end else if (lp_req_i.pstop) begin
            state_nxt = scqs_pkg::ST_PSTOP;
          end else if (lp_req_i.wait_m) begin
            state_nxt = scqs_pkg::ST_WAIT;
          end
        end
        scqs_pkg::ST_SCM: begin
          // self clock runs on; only a reset leaves it
          state_nxt = scqs_pkg::ST_SCM;
        end
        scqs_pkg::ST_STOP: begin
          // only an external interrupt wakes full stop
          if (wake_i.irq_ext) begin
            state_nxt    = scqs_pkg::ST_CQC;
            irq_path_nxt = 1'b1;
            tout_nxt     = 25'h0;
            tick_nxt     = 16'h0000;
          end
        end
        scqs_pkg::ST_PSTOP: begin
          if (woke) begin
            state_nxt = scqs_pkg::ST_VUP;
          end
        end
        scqs_pkg::ST_WAIT: begin
          if (woke) begin
            state_nxt = scqs_pkg::ST_WRS;
            wrs_nxt   = 4'h1;
          end
        end
        scqs_pkg::ST_VUP: begin
          // regulator must be back before the recovery delay starts
          if (reg_full_i) begin
            state_nxt = scqs_pkg::ST_WRS;
            wrs_nxt   = 4'h1;
          end
        end
        scqs_pkg::ST_WRS: begin
          // vector pulse lands on cycle 14 after the wake
          if (wrs_r == `SCQS_WRS_CYC - 4'h1) begin
            state_nxt = scqs_pkg::ST_RUN;
            fiv_nxt   = 1'b1;
          end else begin
            wrs_nxt = wrs_r + 4'h1;
          end
        end
        default: begin
          state_nxt = scqs_pkg::ST_RESET;
        end
      endcase
    end
  end

  // state registers; reset comes up holding internal reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r    <= scqs_pkg::ST_RESET;
      tout_r     <= 25'h0;
      tick_r     <= 16'h0000;
      rpin_r     <= 2'h0;
      osc_ok_r   <= 1'b0;
      irq_path_r <= 1'b0;
      power_on_reset_flag_r     <= `SCQS_RST_POWER_ON_RESET_FLAG;
      sel_r      <= `SCQS_RST_OSC_SEL;
      frv_r      <= 1'b0;
      fiv_r      <= 1'b0;
      wrs_r      <= 4'h0;
    end else begin
      state_r    <= state_nxt;
      tout_r     <= tout_nxt;
      tick_r     <= tick_nxt;
      rpin_r     <= rpin_nxt;
      osc_ok_r   <= osc_ok_nxt;
      irq_path_r <= irq_path_nxt;
      power_on_reset_flag_r     <= power_on_reset_flag_nxt;
      sel_r      <= sel_nxt;
      frv_r      <= frv_nxt;
      fiv_r      <= fiv_nxt;
      wrs_r      <= wrs_nxt;
    end
  end

  // output decode taken from the next state, so each output has its own
  // flop yet changes on the same edge as the state it reflects
  always_comb begin
    osc_en_nxt  = (state_nxt != scqs_pkg::ST_STOP);
    sys_osc_nxt = osc_live(state_nxt);
    scm_nxt     = (state_nxt == scqs_pkg::ST_SCM);
    cq_nxt      = (state_nxt == scqs_pkg::ST_CQC);
    red_nxt     = (state_nxt == scqs_pkg::ST_PSTOP) ||
                  (state_nxt == scqs_pkg::ST_VUP);
    // a check after stop wake runs without internal reset
    irst_nxt    = (state_nxt == scqs_pkg::ST_RESET) ||
                  ((state_nxt == scqs_pkg::ST_CQC) && !irq_path_nxt);
  end

  // output flops; reset values match the reset state
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      osc_en_r  <= 1'b1;
      sys_osc_r <= 1'b0;
      scm_r     <= 1'b0;
      cq_r      <= 1'b0;
      red_r     <= 1'b0;
      irst_r    <= 1'b1;
    end else begin
      osc_en_r  <= osc_en_nxt;
      sys_osc_r <= sys_osc_nxt;
      scm_r     <= scm_nxt;
      cq_r      <= cq_nxt;
      red_r     <= red_nxt;
      irst_r    <= irst_nxt;
    end
  end

  // every output leaves straight from a flop
  assign osc_enable_o          = osc_en_r;                   // off in stop, keeps it in pstop
  assign sys_clk_osc_o         = sys_osc_r;
  assign self_clock_mode_o     = scm_r;
  assign cq_active_o           = cq_r;
  assign reg_reduced_o         = red_r;
  assign int_reset_o           = irst_r;
  assign fetch_rst_vec_o       = frv_r;
  assign fetch_irq_vec_o       = fiv_r;
  assign osc_select_o          = sel_r;
  assign power_on_reset_flag_o = power_on_reset_flag_r;
  assign clk_mon_fail_o        = mon_fail;

endmodule

// ---- verification/scqs_osc_model.sv ----
/*
  oscillator model: one edge pulse per core cycle while it runs.
  assumes the bench starts or kills the crystal through run_i.
*/
`timescale 1ns/100ps

module scqs_osc_model (
  // enables
  input  wire logic osc_enable_i,
  input  wire logic run_i,
  // edge pulse
  output logic      osc_tick_o
);
  // no edges when disabled or dead, and none while the enable is unknown
  always_comb osc_tick_o = (osc_enable_i === 1'b1) && run_i;
endmodule

// ---- verification/scqs_seq_sva.sv ----
/*
  port checker for the sequencer.
  assumes it is bound onto scqs_seq, single clock domain.
*/
`timescale 1ns/100ps

module scqs_seq_sva #(
  parameter int unsigned CQ_TOUT_CYC = 200
) (
  // clock and reset
  input wire logic                 core_clk_i,
  input wire logic                 rstn_i,
  // inputs
  input wire logic                 por_i,
  input wire logic                 low_voltage_reset_i,
  input wire logic                 ext_rst_n_i,
  input wire logic                 osc_tick_i,
  input wire scqs_pkg::scqs_wake_s wake_i,
  input wire logic                 reg_full_i,
  // outputs
  input wire logic                 osc_enable_o,
  input wire logic                 sys_clk_osc_o,
  input wire logic                 self_clock_mode_o,
  input wire logic                 cq_active_o,
  input wire logic                 reg_reduced_o,
  input wire logic                 osc_select_o,
  input wire logic                 int_reset_o,
  input wire logic                 fetch_rst_vec_o,
  input wire logic                 fetch_irq_vec_o,
  input wire logic                 power_on_reset_flag_o,
  input wire logic                 clk_mon_fail_o
);
  logic [31:0] cq_cnt_r, cq_cnt_nxt; // cycles spent in the check
  logic [15:0] gap_r, gap_nxt;       // monitored cycles without a tick

  // helper counters, next values
  always_comb begin
    cq_cnt_nxt = cq_active_o ? cq_cnt_r + 32'h1 : 32'h0;
    gap_nxt    = (sys_clk_osc_o && !osc_tick_i) ? gap_r + 16'h1 : 16'h0;
  end
  // registered; cleared in reset so no stale count leaks across
  always_ff @(posedge core_clk_i) begin
    cq_cnt_r <= rstn_i ? cq_cnt_nxt : 32'h0;
    gap_r    <= rstn_i ? gap_nxt : 16'h0;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_por_start; $fell(por_i) && ext_rst_n_i && !low_voltage_reset_i |-> ##[1:2] cq_active_o; endproperty
  a_por_start: assert property (p_por_start) else $error("no check after supply release");
  property p_lvr_start; $fell(low_voltage_reset_i) && ext_rst_n_i && !por_i |-> ##[1:2] cq_active_o; endproperty
  a_lvr_start: assert property (p_lvr_start) else $error("no check after low-voltage release");
  property p_scm; $rose(self_clock_mode_o) |-> $past(cq_active_o) && !sys_clk_osc_o; endproperty
  a_scm: assert property (p_scm) else $error("self clock entered outside the check");
  property p_tout; cq_cnt_r <= CQ_TOUT_CYC + 2; endproperty
  a_tout: assert property (p_tout) else $error("check outlived its time-out");
  property p_rvec; fetch_rst_vec_o |-> $past(int_reset_o); endproperty
  a_rvec: assert property (p_rvec) else $error("reset vector without internal reset");
  property p_wake; fetch_irq_vec_o && !$past(cq_active_o) |-> $past(wake_i.irq_int || wake_i.irq_ext, 14)
    || $past(reg_full_i, 14); endproperty
  a_wake: assert property (p_wake) else $error("wake vector not 14 cycles after cause");
  property p_vup; $fell(reg_reduced_o) |-> ##13 fetch_irq_vec_o; endproperty
  a_vup: assert property (p_vup) else $error("no vector after regulator recovery");
  property p_pstop; reg_reduced_o |-> osc_enable_o && sys_clk_osc_o; endproperty
  a_pstop: assert property (p_pstop) else $error("oscillator off in pseudo stop");
  property p_stop_wake; $rose(osc_enable_o) |-> cq_active_o && !int_reset_o; endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake skipped the check");
  property p_strap; !int_reset_o |=> $stable(osc_select_o); endproperty
  a_strap: assert property (p_strap) else $error("strap moved outside reset");
  property p_mon_late; gap_r > 16'h019A |-> clk_mon_fail_o; endproperty
  a_mon_late: assert property (p_mon_late) else $error("slow clock not flagged");
  property p_mon_early; $rose(clk_mon_fail_o) |-> gap_r >= 16'h018A; endproperty
  a_mon_early: assert property (p_mon_early) else $error("monitor flagged too early");
  property p_power_on_reset_flag; por_i |=> power_on_reset_flag_o; endproperty
  a_power_on_reset_flag: assert property (p_power_on_reset_flag) else $error("power-on flag not set");
endmodule

// ---- verification/testbench.sv ----
/*
  testbench for the sequencer: one task per scenario, oscillator model alongside.
  assumes package, sequencer, model and checker are compiled first.
*/
`timescale 1ns/100ps

module testbench;
  localparam int unsigned CQ_TOUT_CYC = 6000; // short time-out, still above 4096 edges
  logic clk = 1'b0, rstn = 1'b0, por = 1'b0, low_voltage_reset = 1'b0, pin_n = 1'b1, strap = 1'b0;
  logic reg_full = 1'b0, power_on_reset_flag_clr = 1'b0, run = 1'b0, tick;
  scqs_pkg::scqs_lp_req_s lp = 3'h0;  // {stop, pstop, wait_m}
  scqs_pkg::scqs_wake_s   wake = 2'h0; // {irq_int, irq_ext}
  logic osc_en, sys_osc, scm, cq, red, osel, irst, frv, fiv, power_on_reset_flag, mfail;
  int   n_mismatch = 0, tests_run = 0;

  always #12.5 clk = ~clk; // 40 MHz

  scqs_seq #(.CQ_TOUT_CYC(CQ_TOUT_CYC)) uut (.core_clk_i(clk), .rstn_i(rstn), .por_i(por),
    .low_voltage_reset_i(low_voltage_reset), .ext_rst_n_i(pin_n), .osc_tick_i(tick), .osc_select_strap_i(strap),
    .lp_req_i(lp), .wake_i(wake), .reg_full_i(reg_full), .power_on_reset_flag_clr_i(power_on_reset_flag_clr), .osc_enable_o(osc_en),
    .sys_clk_osc_o(sys_osc), .self_clock_mode_o(scm), .cq_active_o(cq), .reg_reduced_o(red),
    .osc_select_o(osel), .int_reset_o(irst), .fetch_rst_vec_o(frv), .fetch_irq_vec_o(fiv),
    .power_on_reset_flag_o(power_on_reset_flag), .clk_mon_fail_o(mfail));
  scqs_osc_model partner (.osc_enable_i(osc_en), .run_i(run), .osc_tick_o(tick));

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // single-bit compare, unknown never matches
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // cycle count compare against a window
  task automatic chk_cnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, lo);
    end
  endtask
  // edges until reset vector (0), wake vector (1) or monitor fail (2); bounded
  task automatic wait_ev(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge clk);
      #1;
      n++;
      hit = (sel == 0) ? (frv === 1'b1) : (sel == 1) ? (fiv === 1'b1) : (mfail === 1'b1);
    end
    if (!hit) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // one-cycle pulse on wake or low power request, sampled at the following edge
  task automatic pulse(input logic [2:0] lp_v, input logic [1:0] wk_v);
    @(posedge clk);
    lp <= lp_v;
    wake <= wk_v;
    @(posedge clk);
    lp <= 3'h0;
    wake <= 2'h0;
  endtask

  // low-voltage release with a dead crystal: fallback after the time-out
  task automatic t_lvr_dead();
    int n;
    @(posedge clk);
    low_voltage_reset <= 1'b1;
    repeat (3) @(posedge clk);
    low_voltage_reset <= 1'b0;
    wait_ev(0, CQ_TOUT_CYC + 20, n);
    chk_bit(scm, 1'b1);
    chk_cnt(n, CQ_TOUT_CYC, CQ_TOUT_CYC + 4);
    chk_bit(osel, 1'b0);
  endtask
  // power-on with a live crystal: check passes, strap latched, flag set then cleared
  task automatic t_por();
    int n;
    @(posedge clk);
    strap <= 1'b1;
    por <= 1'b1;
    run <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    wait_ev(0, CQ_TOUT_CYC, n);
    chk_bit(scm, 1'b0);
    chk_cnt(n, 4096, 4112);
    chk_bit(osel, 1'b1);
    chk_bit(power_on_reset_flag, 1'b1);
    @(posedge clk);
    strap <= 1'b0;
    power_on_reset_flag_clr <= 1'b1;
    @(posedge clk);
    power_on_reset_flag_clr <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(power_on_reset_flag, 1'b0);
  endtask
  // pin reset: a one-cycle glitch is ignored, a long one resets without a check
  task automatic t_pin();
    int n;
    @(posedge clk);
    pin_n <= 1'b0;
    @(posedge clk);
    pin_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(irst, 1'b0);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    wait_ev(0, 20, n);
    chk_bit(cq, 1'b0);
    chk_bit(osel, 1'b0);
    chk_bit(power_on_reset_flag, 1'b0);
  endtask
  // wait mode, internal interrupt wake
  task automatic t_wait();
    int n;
    pulse(3'h1, 2'h0);
    repeat (3) @(posedge clk);
    pulse(3'h0, 2'h2);
    wait_ev(1, 30, n);
    // vector flop launched 13 edges after the wake edge, taken at the 14th
    chk_cnt(n, 13, 13);
  endtask
  // pseudo stop, external wake, slow regulator
  task automatic t_pstop();
    int n;
    pulse(3'h2, 2'h0);
    @(posedge clk);
    #1;
    chk_bit(red, 1'b1);
    chk_bit(osc_en, 1'b1);
    pulse(3'h0, 2'h1);
    repeat (5) @(posedge clk);
    reg_full <= 1'b1;
    @(posedge clk);
    reg_full <= 1'b0;
    wait_ev(1, 30, n);
    chk_cnt(n, 13, 13);
  endtask
  // full stop: internal interrupt does not wake, external one runs the check
  task automatic t_stop();
    int n;
    pulse(3'h4, 2'h0);
    pulse(3'h0, 2'h2);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(osc_en, 1'b0);
    pulse(3'h0, 2'h1);
    wait_ev(1, CQ_TOUT_CYC, n);
    chk_cnt(n, 4096, 4112);
  endtask
  // crystal dies in run: monitor flags it and the check restarts
  task automatic t_mon();
    int n;
    @(posedge clk);
    run <= 1'b0;
    wait_ev(2, 500, n);
    chk_cnt(n, 395, 410);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(cq, 1'b1);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_lvr_dead();
    t_por();
    t_pin();
    t_wait();
    t_pstop();
    t_stop();
    t_mon();
    stop_test();
  end
endmodule

bind scqs_seq scqs_seq_sva #(.CQ_TOUT_CYC(CQ_TOUT_CYC)) u_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .por_i(por_i), .low_voltage_reset_i(low_voltage_reset_i), .ext_rst_n_i(ext_rst_n_i), .osc_tick_i(osc_tick_i),
  .wake_i(wake_i), .reg_full_i(reg_full_i), .osc_enable_o(osc_enable_o), .sys_clk_osc_o(sys_clk_osc_o),
  .self_clock_mode_o(self_clock_mode_o), .cq_active_o(cq_active_o), .reg_reduced_o(reg_reduced_o),
  .osc_select_o(osc_select_o), .int_reset_o(int_reset_o), .fetch_rst_vec_o(fetch_rst_vec_o),
  .fetch_irq_vec_o(fetch_irq_vec_o), .power_on_reset_flag_o(power_on_reset_flag_o),
  .clk_mon_fail_o(clk_mon_fail_o));
